// ---- core/srs_top.sv ----
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module srs_top
  import srs_pkg::*;
#(
  parameter int DLY0 = 16,
  parameter int DLY1 = 256,
  parameter int DLY2 = 1024,
  parameter int DLY3 = 4096,
  parameter int CNT_W = 14
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire srs_axi_req_t axi_req,
  output srs_axi_rsp_t axi_rsp,
  input wire srs_pins_t pins,
  output logic cpu_reset_n,
  output logic io_reset_n,
  output logic vector_start,
  output logic irq
);

  // ************************************************
  // elaboration checks
  // ************************************************
  // the clock-select fuse may double the longest delay, so it must fit
  if (2 * DLY3 >= 2 ** CNT_W || DLY0 < 1 || DLY1 < 1 || DLY2 < 1) begin : g_chk
    $error("srs_top: delay parameters do not fit the counter");
  end

  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    srs_pins_t sync1;
    srs_pins_t sync2;
    logic [1:0] boot;
    logic wdt_prev;
    logic wdt_pulse;
    logic [FILT_W-1:0] ext_cnt;
    logic ext_act;
    logic bod_low;
    logic [FILT_W-1:0] bod_cnt;
    logic bod_act;
    logic [NUM_SRC-1:0] src_prev;
    logic [CNT_W-1:0] dly_cnt;
    logic cpu_rst_n;
    logic vec_start;
    logic [NUM_SRC-1:0] cause;
    logic [NUM_SRC-1:0] irq_st;
    logic [NUM_SRC-1:0] irq_mask;
    logic irq;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } srs_st_t;

  // all zero: internal reset held, bus idle, flags clear
  localparam srs_st_t ST_RST = '0;

  srs_st_t st_q;
  srs_st_t st_d;
  srs_pins_t p;
  logic [NUM_SRC-1:0] cur;
  logic [NUM_SRC-1:0] ev;
  logic [NUM_SRC-1:0] keep;
  logic [NUM_SRC-1:0] rd_clr;
  logic [CNT_W-1:0] dly_sel;
  logic req;
  logic boot_hold;
  logic bod_en;
  logic io_async;
  logic io_rst_n_q;

  // ************************************************
  // functions
  // ************************************************
  // stretch length from the start-up and clock-select fuses
  function automatic logic [CNT_W-1:0] dly_cycles(input srs_fuse_t f);
    logic [CNT_W-1:0] base;
    case (f.startup_time_fuse)
      2'h0: base = CNT_W'(DLY0);
      2'h1: base = CNT_W'(DLY1);
      2'h2: base = CNT_W'(DLY2);
      default: base = CNT_W'(DLY3);
    endcase
    // slow clock sources get twice the settling time
    if (f.clock_select_fuse[0]) begin
      base = CNT_W'({base, 1'b0});
    end
    return base;
  endfunction : dly_cycles

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == REG_CAUSE) || (a == REG_IRQ_ST) || (a == REG_IRQ_MASK) ||
           (a == REG_STATE);
  endfunction : is_mapped

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    st_d = st_q;
    keep = '1;
    rd_clr = '0;
    cur = '0;
    // two flops on every pin, fuses included
    st_d.sync1 = pins;
    st_d.sync2 = st_q.sync1;
    p = st_q.sync2;
    dly_sel = dly_cycles(p.fuse);

    // the sync stage holds zeros just after block reset, so the fuses are not
    // valid yet; keep reloading until they are, then stretch as for any source
    boot_hold = (st_q.boot != BOOT_DONE);
    if (boot_hold) begin
      st_d.boot = st_q.boot + 1'b1;
    end

    // watchdog: rising expiry while enabled gives one pulse
    st_d.wdt_prev = p.src.wdt_expire;
    st_d.wdt_pulse = p.src.wdt_expire & ~st_q.wdt_prev & p.src.wdt_enable;

    // pin filter: short lows never reach the request
    if (!p.src.reset_pin_n) begin
      if (st_q.ext_cnt != RST_FILT) begin
        st_d.ext_cnt = st_q.ext_cnt + 1'b1;
      end
    end else begin
      st_d.ext_cnt = '0;
    end
    st_d.ext_act = (st_d.ext_cnt == RST_FILT);

    // brown-out: two comparators give the hysteresis band
    bod_en = (p.fuse.brownout_level_fuse != BOD_OFF_CODE);
    if (st_q.bod_low) begin
      st_d.bod_low = bod_en & p.src.bod_below_hi;
    end else begin
      st_d.bod_low = bod_en & p.src.bod_below_lo;
    end
    if (st_d.bod_low) begin
      if (st_q.bod_cnt != BOD_FILT) begin
        st_d.bod_cnt = st_q.bod_cnt + 1'b1;
      end
    end else begin
      st_d.bod_cnt = '0;
    end
    st_d.bod_act = st_d.bod_low & (st_d.bod_cnt == BOD_FILT);

    // the five sources and their combined request
    cur[SRC_POR] = p.src.por_below;
    cur[SRC_EXT] = st_q.ext_act;
    cur[SRC_BOD] = st_q.bod_act;
    cur[SRC_WDT] = st_q.wdt_pulse;
    cur[SRC_SCAN] = p.src.scan_reset;
    req = |cur;
    st_d.src_prev = cur;
    ev = cur & ~st_q.src_prev;

    // delay counter: reloads while any source is active
    if (req || boot_hold) begin
      st_d.dly_cnt = dly_sel;
    end else if (st_q.dly_cnt != '0) begin
      st_d.dly_cnt = st_q.dly_cnt - 1'b1;
    end
    st_d.cpu_rst_n = ~(req | boot_hold | (st_d.dly_cnt != '0));
    st_d.vec_start = ~st_q.cpu_rst_n & st_d.cpu_rst_n;

    // bus write channels, taken in either order
    if (axi_req.awvalid && st_q.awready) begin
      st_d.aw_have = 1'b1;
      st_d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_q.wready) begin
      st_d.w_have = 1'b1;
      st_d.wdata = axi_req.wdata;
      st_d.wstrb = axi_req.wstrb;
    end
    if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = is_mapped(st_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (st_q.wstrb[0]) begin
        case (st_q.awaddr)
          // writing zero clears a flag, writing one leaves it
          REG_CAUSE: keep = st_q.wdata[NUM_SRC-1:0];
          REG_IRQ_MASK: st_d.irq_mask = st_q.wdata[NUM_SRC-1:0];
          default: keep = '1;
        endcase
      end
    end
    if (st_q.bvalid && axi_req.bready) begin
      st_d.bvalid = 1'b0;
    end
    // one write at a time: both readies drop until the answer is taken
    st_d.awready = ~st_d.aw_have & ~st_d.bvalid;
    st_d.wready = ~st_d.w_have & ~st_d.bvalid;

    // bus read: data one cycle after the address is taken
    if (axi_req.arvalid && st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = is_mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      st_d.rdata = '0;
      case (axi_req.araddr)
        REG_CAUSE: st_d.rdata[NUM_SRC-1:0] = st_q.cause;
        REG_IRQ_ST: begin
          st_d.rdata[NUM_SRC-1:0] = st_q.irq_st;
          rd_clr = '1;
        end
        REG_IRQ_MASK: st_d.rdata[NUM_SRC-1:0] = st_q.irq_mask;
        REG_STATE: begin
          st_d.rdata[NUM_SRC-1:0] = cur;
          st_d.rdata[ST_RST_BIT] = ~st_q.cpu_rst_n;
          st_d.rdata[ST_BODEN_BIT] = bod_en;
          st_d.rdata[ST_BODLOW_BIT] = st_q.bod_low;
        end
        default: st_d.rdata = '0;
      endcase
    end
    if (st_q.rvalid && axi_req.rready) begin
      st_d.rvalid = 1'b0;
    end
    st_d.arready = ~st_d.rvalid;

    // cause flags: power-on wipes the rest, new causes beat a clear
    if (cur[SRC_POR]) begin
      st_d.cause = CAUSE_POR_ONLY;
    end else begin
      st_d.cause = (st_q.cause & keep) | cur;
    end

    // interrupt: events are sticky, a read clears, an event wins
    st_d.irq_st = (st_q.irq_st & ~rd_clr) | ev;
    st_d.irq = |(st_d.irq_st & st_d.irq_mask);

    if (!rstn) begin
      st_d = ST_RST;
    end
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge mclk) begin
    st_q <= st_d;
  end

  // port reset path: raw pin, supply and scan levels act with no clock;
  // brown-out stays on the filtered path so short dips cannot reach ports
  assign io_async = ~pins.src.reset_pin_n | pins.src.por_below | pins.src.scan_reset;

  always_ff @(posedge mclk or posedge io_async) begin
    if (io_async) begin
      io_rst_n_q <= 1'b0;
    end else begin
      io_rst_n_q <= rstn & st_d.cpu_rst_n;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign cpu_reset_n = st_q.cpu_rst_n;
  assign io_reset_n = io_rst_n_q;
  assign vector_start = st_q.vec_start;
  assign irq = st_q.irq;
  assign axi_rsp.awready = st_q.awready;
  assign axi_rsp.wready = st_q.wready;
  assign axi_rsp.bresp = st_q.bresp;
  assign axi_rsp.bvalid = st_q.bvalid;
  assign axi_rsp.arready = st_q.arready;
  assign axi_rsp.rdata = st_q.rdata;
  assign axi_rsp.rresp = st_q.rresp;
  assign axi_rsp.rvalid = st_q.rvalid;

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // last tick of the stretch
  sequence s_last_tick;
    !req && !boot_hold && (st_q.dly_cnt == 1);
  endsequence

  sequence s_released;
    st_q.cpu_rst_n && st_q.vec_start;
  endsequence

  sequence s_wdt_then_quiet;
    st_q.wdt_pulse ##1 !req;
  endsequence

  a_wdt_one_cycle: assert property (
    st_q.wdt_pulse |=> !st_q.wdt_pulse && !st_q.cpu_rst_n)
    else $error("watchdog pulse longer than one cycle");

  a_wdt_needs_enable: assert property (
    $rose(st_q.wdt_pulse) |-> $past(p.src.wdt_enable) && $past(p.src.wdt_expire))
    else $error("watchdog reset without enable or expiry");

  a_wdt_trailing_count: assert property (
    s_wdt_then_quiet |=> st_q.dly_cnt == $past(st_q.dly_cnt) - 1)
    else $error("delay not counting after watchdog pulse");

  a_request_resets: assert property (
    req |=> !st_q.cpu_rst_n)
    else $error("active source did not hold reset");

  a_delay_reload: assert property (
    req |=> st_q.dly_cnt == $past(dly_sel))
    else $error("delay counter not reloaded by a source");

  a_stretch_hold: assert property (
    (!req && st_q.dly_cnt > 1) |=> !st_q.cpu_rst_n)
    else $error("reset released before time-out");

  a_release_vector: assert property (
    s_last_tick |=> s_released)
    else $error("reset not released with vector start at time-out");

  a_ext_filter: assert property (
    $rose(st_q.ext_act) |-> $past(st_q.ext_cnt) == RST_FILT - 1)
    else $error("pin reset accepted before minimum width");

  a_bod_filter: assert property (
    $rose(st_q.bod_act) |-> $past(st_q.bod_cnt) == BOD_FILT - 1)
    else $error("brown-out accepted before minimum width");

  a_bod_disabled: assert property (
    !bod_en |=> !st_q.bod_low && !st_q.bod_act)
    else $error("brown-out active while disabled");

  a_scan_hold: assert property (
    p.src.scan_reset [*2] |-> !st_q.cpu_rst_n)
    else $error("scan reset bit did not hold the processor");

  a_por_cause: assert property (
    p.src.por_below |=> st_q.cause == CAUSE_POR_ONLY)
    else $error("power-on did not clear the other causes");

  a_io_follows: assert property (
    !st_q.cpu_rst_n |-> !io_reset_n)
    else $error("ports out of reset while reset held");

  a_irq_level: assert property (
    st_q.irq == |(st_q.irq_st & st_q.irq_mask))
    else $error("interrupt output disagrees with status and mask");

  a_boot_stretch: assert property (
    boot_hold |=> !st_q.cpu_rst_n)
    else $error("processor released before the sync stage settled");

  a_vector_single: assert property (
    st_q.vec_start |=> !st_q.vec_start)
    else $error("vector start longer than one cycle");

  a_por_at_once: assert property (
    p.src.por_below |=> !st_q.cpu_rst_n)
    else $error("power-on did not reset at once");

  a_bod_hyst_hold: assert property (
    (st_q.bod_low && bod_en && p.src.bod_below_hi) |=> st_q.bod_low)
    else $error("brown-out left inside the hysteresis band");

endmodule : srs_top

`default_nettype wire

// ---- pkg/srs_pkg.sv ----
package srs_pkg;

  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RST_MIN_NS = 400;
  localparam int T_BOD_MIN_NS = 2000;
  localparam int HYST_MV = 70;
  localparam int RST_FILT_CYC = (T_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOD_FILT_CYC = (T_BOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_W = $clog2(BOD_FILT_CYC + 1);
  localparam logic [FILT_W-1:0] RST_FILT = FILT_W'(RST_FILT_CYC);
  localparam logic [FILT_W-1:0] BOD_FILT = FILT_W'(BOD_FILT_CYC);
  // edges after block reset before the synchronised pins and fuses are trusted
  localparam logic [1:0] BOOT_DONE = 2'h3;

  // ************************************************
  // register map and fields
  // ************************************************
  localparam int ADDR_W = 8;
  localparam int NUM_SRC = 5;
  localparam logic [ADDR_W-1:0] REG_CAUSE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_IRQ_ST = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h0c;
  localparam int SRC_POR = 0;
  localparam int SRC_EXT = 1;
  localparam int SRC_BOD = 2;
  localparam int SRC_WDT = 3;
  localparam int SRC_SCAN = 4;
  localparam int ST_RST_BIT = 5;
  localparam int ST_BODEN_BIT = 6;
  localparam int ST_BODLOW_BIT = 7;
  localparam logic [NUM_SRC-1:0] CAUSE_POR_ONLY = 5'h01;
  localparam logic [2:0] BOD_OFF_CODE = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************
  // carriers
  // ************************************************
  typedef struct packed {
    logic por_below;
    logic reset_pin_n;
    logic wdt_expire;
    logic wdt_enable;
    logic bod_below_hi;
    logic bod_below_lo;
    logic scan_reset;
  } srs_src_t;

  typedef struct packed {
    logic [2:0] brownout_level_fuse;
    logic [1:0] startup_time_fuse;
    logic [3:0] clock_select_fuse;
  } srs_fuse_t;

  typedef struct packed {
    srs_src_t src;
    srs_fuse_t fuse;
  } srs_pins_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } srs_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } srs_axi_rsp_t;

endpackage : srs_pkg

// ---- verification/srs_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// *****
// far side: supply monitors, reset pin, watchdog and scan bit
// *****
module srs_partner
  import srs_pkg::*;
#(
  parameter logic [12:0] POR_MV = 13'h578
) (
  input wire logic [12:0] supply_mv,
  input wire logic pin_low,
  input wire logic wdt_fire,
  input wire logic wdt_en,
  input wire logic scan_set,
  input wire srs_fuse_t fuse,
  output srs_pins_t pins
);
  logic [12:0] nom;
  // trip level rises with the code; off code keeps the top level, device ignores it
  always_comb begin
    case (fuse.brownout_level_fuse)
      3'h0: nom = 13'h9c4;
      3'h1: nom = 13'ha28;
      3'h2: nom = 13'ha8c;
      3'h3: nom = 13'hed8;
      3'h4: nom = 13'hf3c;
      3'h5: nom = 13'hfa0;
      default: nom = 13'h1004;
    endcase
  end
  // two comparators make the band, so a trip needs the lower one
  assign pins.src.bod_below_hi = supply_mv < nom + 13'(HYST_MV / 2);
  assign pins.src.bod_below_lo = supply_mv < nom - 13'(HYST_MV / 2);
  assign pins.src.por_below = supply_mv < POR_MV;
  assign pins.src.reset_pin_n = ~pin_low;
  assign pins.src.wdt_expire = wdt_fire;
  assign pins.src.wdt_enable = wdt_en;
  assign pins.src.scan_reset = scan_set;
  assign pins.fuse = fuse;
endmodule : srs_partner
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
  import srs_pkg::*;
;
  localparam int D0 = 10;
  localparam int D1 = 14;
  localparam int D2 = 20;
  localparam int D3 = 26;
  logic mclk, rstn, pin_low, wdt_fire, wdt_en, scan_set, ok;
  logic cpu_reset_n, io_reset_n, vector_start, irq;
  logic [12:0] supply_mv;
  logic [31:0] rd;
  logic [1:0] rsp;
  srs_axi_req_t req;
  srs_axi_rsp_t axi_rsp;
  srs_pins_t pins;
  srs_fuse_t fuse;
  int fail_count, checks_done, seed, k;

  srs_partner srs_partner_i (.supply_mv(supply_mv), .pin_low(pin_low), .wdt_fire(wdt_fire),
    .wdt_en(wdt_en), .scan_set(scan_set), .fuse(fuse), .pins(pins));
  // short delays keep the run brief; expectations follow from them
  srs_top #(.DLY0(D0), .DLY1(D1), .DLY2(D2), .DLY3(D3), .CNT_W(14)) srs_top_i (
    .mclk(mclk), .rstn(rstn), .axi_req(req), .axi_rsp(axi_rsp), .pins(pins),
    .cpu_reset_n(cpu_reset_n), .io_reset_n(io_reset_n), .vector_start(vector_start),
    .irq(irq));

  // *****
  // helpers
  // *****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  function automatic int dly(input srs_fuse_t f);
    int b;
    b = (f.startup_time_fuse == 2'h0) ? D0 : (f.startup_time_fuse == 2'h1) ? D1 :
        (f.startup_time_fuse == 2'h2) ? D2 : D3;
    return f.clock_select_fuse[0] ? 2 * b : b;
  endfunction : dly

  task automatic fire();
    @(posedge mclk);
    wdt_fire <= 1'b1;
    @(posedge mclk);
    wdt_fire <= 1'b0;
  endtask : fire

  // waits for reset to be held, then counts the held cycles
  task automatic wait_release();
    int n;
    n = 0;
    while (cpu_reset_n !== 1'b0 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (cpu_reset_n !== 1'b1 && n < 1000);
    ok = n >= dly(fuse) && n <= dly(fuse) + 10;
    chk({31'h0, ok}, 32'h1);
    chk({31'h0, vector_start}, 32'h1);
    @(posedge mclk);
    chk({31'h0, vector_start}, 32'h0);
  endtask : wait_release

  task automatic hold_high(input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(posedge mclk);
      if (cpu_reset_n !== 1'b1) bad = 1'b1;
    end
    chk({31'h0, bad}, 32'h0);
  endtask : hold_high

  // register bus master: each channel released at its own handshake
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (req.awvalid && axi_rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && axi_rsp.wready) req.wvalid <= 1'b0;
    end while (axi_rsp.bvalid !== 1'b1 && n < 100);
    chk({31'h0, axi_rsp.bvalid}, 32'h1);
    rsp = axi_rsp.bresp;
    req.bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (req.arvalid && axi_rsp.arready) req.arvalid <= 1'b0;
    end while (axi_rsp.rvalid !== 1'b1 && n < 100);
    chk({31'h0, axi_rsp.rvalid}, 32'h1);
    rd = axi_rsp.rdata;
    rsp = axi_rsp.rresp;
    req.rready <= 1'b0;
  endtask : axi_rd

  // *****
  // clock, cut-off and scenarios
  // *****
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // a hang ends the run well after the expected span of about 40 us
  initial begin
    #300000;
    fail_count++;
    end_of_test();
  end

  initial begin
    seed = 32'h7538;
    fail_count = 0;
    checks_done = 0;
    rstn = 1'b0;
    req = '0;
    supply_mv = 13'h1388;
    pin_low = 1'b0;
    wdt_fire = 1'b0;
    wdt_en = 1'b0;
    scan_set = 1'b0;
    fuse = '{brownout_level_fuse: 3'h7, startup_time_fuse: 2'h0, clock_select_fuse: 4'h0};
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    wait_release();
    // watchdog: disabled expiry ignored, enabled expiry stretched by each delay choice
    for (k = 0; k < 4; k++) begin
      @(posedge mclk);
      fuse.startup_time_fuse <= 2'(k);
      fuse.clock_select_fuse <= 4'($random(seed));
      wdt_en <= 1'b0;
      cyc(4);
      fire();
      hold_high(30);
      wdt_en <= 1'b1;
      cyc(4);
      fire();
      wait_release();
    end
    axi_rd(REG_CAUSE);
    chk(rd & 32'h8, 32'h8);
    // power-on: ports drop with no clock edge, cause keeps only its own bit
    @(posedge mclk);
    supply_mv <= 13'h3e8;
    #1;
    chk({31'h0, io_reset_n}, 32'h0);
    cyc(20);
    supply_mv <= 13'h1388;
    wait_release();
    axi_rd(REG_CAUSE);
    chk(rd, {27'h0, CAUSE_POR_ONLY});
    axi_wr(REG_CAUSE, 32'h1f);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    axi_rd(REG_CAUSE);
    chk(rd, 32'h1);
    axi_wr(REG_CAUSE, 32'h0);
    axi_rd(REG_CAUSE);
    chk(rd, 32'h0);
    // reset pin: a random short low leaves the processor running, a long low resets
    @(posedge mclk);
    pin_low <= 1'b1;
    cyc(20 + {$random(seed)} % 15);
    pin_low <= 1'b0;
    hold_high(30);
    pin_low <= 1'b1;
    #1;
    chk({31'h0, io_reset_n}, 32'h0);
    cyc(60);
    chk({31'h0, cpu_reset_n}, 32'h0);
    pin_low <= 1'b0;
    wait_release();
    // scan bit holds reset; reassertion in the countdown restarts it
    scan_set <= 1'b1;
    cyc(100);
    chk({31'h0, cpu_reset_n}, 32'h0);
    scan_set <= 1'b0;
    cyc(6);
    scan_set <= 1'b1;
    cyc(3);
    scan_set <= 1'b0;
    wait_release();
    // brown-out: off code, short dip, long dip, hysteresis band, recovery
    supply_mv <= 13'hfa0;
    hold_high(250);
    supply_mv <= 13'h1388;
    fuse.brownout_level_fuse <= 3'h6;
    cyc(4);
    supply_mv <= 13'hfa0;
    cyc(150);
    supply_mv <= 13'h1388;
    hold_high(30);
    supply_mv <= 13'hfa0;
    cyc(250);
    chk({31'h0, cpu_reset_n}, 32'h0);
    supply_mv <= 13'h1004;
    cyc(60);
    chk({31'h0, cpu_reset_n}, 32'h0);
    supply_mv <= 13'h1388;
    wait_release();
    for (k = 0; k < 6; k++) begin
      fuse.brownout_level_fuse <= 3'(k);
      cyc(4);
      supply_mv <= 13'hf6e;
      cyc(250);
      chk({31'h0, cpu_reset_n}, {31'h0, k != 5});
      supply_mv <= 13'h1388;
      cyc(dly(fuse) + 20);
    end
    axi_rd(REG_STATE);
    chk({31'h0, rd[ST_BODEN_BIT]}, 32'h1);
    // interrupt: unmasked event raises irq, read clears; masked event stays quiet
    axi_rd(REG_IRQ_ST);
    axi_wr(REG_IRQ_MASK, 32'h8);
    fire();
    wait_release();
    chk({31'h0, irq}, 32'h1);
    axi_rd(REG_IRQ_ST);
    chk(rd, 32'h8);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    axi_wr(REG_IRQ_MASK, 32'h0);
    fire();
    wait_release();
    chk({31'h0, irq}, 32'h0);
    axi_rd(REG_IRQ_ST);
    chk(rd, 32'h8);
    axi_rd(8'h10);
    chk(rd, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
